//--- flc_cfg.svh
// Constants of the serial flash command front: opcodes, status bit places,
// field widths and timing counts.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef FLC_CFG_SVH
`define FLC_CFG_SVH

// ========================================================================
// Opcodes
`define FLC_OP_WR_ENABLE   8'h06
`define FLC_OP_WR_DISABLE  8'h04
`define FLC_OP_RD_STATUS   8'h05
`define FLC_OP_WR_STATUS   8'h01
`define FLC_OP_READ        8'h03
`define FLC_OP_FAST_READ   8'h0b
`define FLC_OP_WRITE_BYTES 8'h02
`define FLC_OP_ERASE_BULK  8'hc7
`define FLC_OP_ERASE_DIE   8'hc4
`define FLC_OP_ERASE_SECT  8'hd8
`define FLC_OP_ERASE_SUB   8'h20
`define FLC_OP_WIDE_ENTER  8'hb7
`define FLC_OP_WIDE_EXIT   8'he9

// ========================================================================
// Status register bit places and reset value
`define FLC_SR_BUSY   0
`define FLC_SR_ARMED  1
`define FLC_SR_BP0    2
`define FLC_SR_BP1    3
`define FLC_SR_BP2    4
`define FLC_SR_BOTTOM 5
`define FLC_SR_BP3    6
`define FLC_SR_RESET  8'h00
`define FLC_SR_WRMASK 8'h7c

// ========================================================================
// Frame layout
`define FLC_OP_BITS      12'd8
`define FLC_BYTE_BITS    12'd8
`define FLC_ADDR_WIDE    12'd32
`define FLC_ADDR_NARROW  12'd24
`define FLC_DUMMY_BITS   12'd8
`define FLC_BITS_MAX     12'hfff
`define FLC_ADDR_MASK    32'h07ffffff
`define FLC_SECT_MASK    32'h07ff0000
`define FLC_SUB_MASK     32'h07fff000
`define FLC_SECT_MSB     26
`define FLC_SECT_LSB     16
`define FLC_SECTORS      12'd2048
`define FLC_BP_ALL       4'd12

// ========================================================================
// Timing: times in microseconds, counts derived from the core clock
`define FLC_CLK_MHZ        20
`define FLC_PROG_TIME_US   500
`define FLC_ERASE_TIME_US  1000
`define FLC_SRWR_TIME_US   100
`define FLC_SRWR_TICKS     (`FLC_SRWR_TIME_US * `FLC_CLK_MHZ)

`endif

//--- flc_front.sv
// Serial flash command front: shifts frames on the host shift clock,
// judges and times modifying operations on the core clock.
// Assumes the host stops its shift clock while select_n is high and that
// the memory array answers array_rd_addr_out within half a shift clock.
`timescale 1ns/1ps
`include "flc_cfg.svh"

// What this block does
// - Fields shift one bit at a time, MSB first
// - Opcode on lane zero, captured on rise
// - Reads drive lane zero until select rises
// - Modifying frames need whole bytes or are dropped
// - Memory access rejected during internal cycle
// - Wide mode uses 32-bit address fields
// - Wide enter acts at once, reset reloads saved mode
// - Only wide exit, or a reset with narrow saved mode, leaves wide mode
// - Protect bits sit at 6, 4, 3, 2
// - Bit 5 anchors region bottom or top
// - Bulk and die erase need zero protect
// - Protected region refuses writes and erases
// - Armed latch gates all modifying operations
// - Bit 0 high during internal cycle
// - Status read any time, repeats while clocked
// - Addresses decode up to 07FFFFFFh
// - Sectors split into sixteen 4 KB subsectors
// - Outgoing data changes on falling edge
module flc_front #(
  parameter logic [23:0] PROG_TICKS  = 24'(`FLC_PROG_TIME_US * `FLC_CLK_MHZ),
  parameter logic [23:0] ERASE_TICKS = 24'(`FLC_ERASE_TIME_US * `FLC_CLK_MHZ)
)
(
  // Core clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    arst_n_in,
  // Serial link
  input  wire logic                    host_shift_clock_in,
  input  wire logic                    select_n_in,
  input  wire logic                    serial_lane_zero_in,
  output logic                         serial_lane_zero_out,
  output logic                         serial_lane_zero_oe_n_out,
  // Memory array, read side on the shift clock
  output logic [31:0]                  array_rd_addr_out,
  input  wire logic [7:0]              array_rd_data_in,
  // Memory array, modify side on the core clock
  output flc_pkg::flc_array_req_t      array_req_out,
  // Status and non-volatile addressing mode
  output logic [7:0]                   status_out,
  output logic                         wide_mode_out,
  input  wire logic                    wide_mode_saved_in
);

  flc_pkg::flc_core_t c;
  flc_pkg::flc_core_t next_c;
  flc_pkg::flc_link_t l;
  flc_pkg::flc_link_t next_l;
  flc_pkg::flc_tx_t   t;
  flc_pkg::flc_tx_t   next_t;
  logic               sel_s;
  logic [8:0]         link_view;
  logic               frame_open;
  logic               frame_rst_n;
  logic               prot_hit;

  // ======================================================================
  // Crossings
  flc_sync #(.W(1)) u_sel_sync
  (
    .clk_in    (clock_in),
    .arst_n_in (arst_n_in),
    .d_in      (select_n_in),
    .q_out     (sel_s)
  );

  flc_sync #(.W(9)) u_status_sync
  (
    .clk_in    (host_shift_clock_in),
    .arst_n_in (arst_n_in),
    .d_in      ({c.wide, c.status}),
    .q_out     (link_view)
  );

  flc_protect u_protect
  (
    .bp_in     ({c.status[`FLC_SR_BP3], c.status[`FLC_SR_BP2],
                 c.status[`FLC_SR_BP1], c.status[`FLC_SR_BP0]}),
    .bottom_in (c.status[`FLC_SR_BOTTOM]),
    .sector_in (l.frame.addr[`FLC_SECT_MSB:`FLC_SECT_LSB]),
    .hit_out   (prot_hit)
  );

  // ======================================================================
  // Core domain: judge the frame once select has risen
  logic [11:0] need_addr;
  logic [11:0] need_data;
  logic        frame_end;
  logic        whole;
  logic        may_modify;

  always_comb
  begin
    next_c           = c;
    next_c.req.start = 1'b0;
    next_c.sel_prev  = sel_s;
    need_addr  = `FLC_OP_BITS + (c.wide ? `FLC_ADDR_WIDE : `FLC_ADDR_NARROW);
    need_data  = need_addr + `FLC_BYTE_BITS;
    frame_end  = sel_s & ~c.sel_prev & c.strap_done;
    whole      = (l.frame.bits[2:0] == 3'h0) &&
                 (l.frame.bits != 12'h000);
    may_modify = whole & c.status[`FLC_SR_ARMED];
    if (!c.strap_done)
    begin
      next_c.strap_done = 1'b1;
      next_c.wide       = wide_mode_saved_in;
    end
    unique case (c.state)
      flc_pkg::FLC_IDLE:
      begin
        if (frame_end && l.frame.bits >= `FLC_OP_BITS)
        begin
          next_c.req.op   = l.frame.opcode;
          next_c.req.data = l.frame.data;
          next_c.req.addr = l.frame.addr & `FLC_ADDR_MASK;
          unique case (l.frame.opcode)
            `FLC_OP_WR_ENABLE:  next_c.status[`FLC_SR_ARMED] = 1'b1;
            `FLC_OP_WR_DISABLE: next_c.status[`FLC_SR_ARMED] = 1'b0;
            `FLC_OP_WIDE_ENTER: next_c.wide = 1'b1;
            `FLC_OP_WIDE_EXIT:  next_c.wide = 1'b0;
            `FLC_OP_WR_STATUS:
            begin
              if (may_modify && l.frame.bits >= 12'd16)
              begin
                next_c.status = (c.status & ~`FLC_SR_WRMASK) |
                                (l.frame.data & `FLC_SR_WRMASK);
                next_c.timer  = 24'(`FLC_SRWR_TICKS);
              end
            end
            `FLC_OP_WRITE_BYTES:
            begin
              if (may_modify && l.frame.bits >= need_data && !prot_hit)
              begin
                next_c.timer = PROG_TICKS;
              end
            end
            `FLC_OP_ERASE_BULK, `FLC_OP_ERASE_DIE:
            begin
              if (may_modify && (c.status & 8'h5c) == 8'h00)
              begin
                next_c.req.addr = 32'h0;
                next_c.timer    = ERASE_TICKS;
              end
            end
            `FLC_OP_ERASE_SECT:
            begin
              if (may_modify && l.frame.bits >= need_addr && !prot_hit)
              begin
                next_c.req.addr = l.frame.addr & `FLC_SECT_MASK;
                next_c.timer    = ERASE_TICKS;
              end
            end
            `FLC_OP_ERASE_SUB:
            begin
              if (may_modify && l.frame.bits >= need_addr && !prot_hit)
              begin
                next_c.req.addr = l.frame.addr & `FLC_SUB_MASK;
                next_c.timer    = ERASE_TICKS;
              end
            end
            default:
            begin
              next_c.timer = 24'h0;
            end
          endcase
          if (next_c.timer != 24'h0)
          begin
            next_c.state               = flc_pkg::FLC_BUSY;
            next_c.req.start           = 1'b1;
            next_c.status[`FLC_SR_BUSY] = 1'b1;
          end
        end
      end
      flc_pkg::FLC_BUSY:
      begin
        // Frames that end now are ignored; the cycle runs on
        next_c.timer = c.timer - 24'h1;
        if (c.timer <= 24'h1)
        begin
          next_c.timer                 = 24'h0;
          next_c.state                 = flc_pkg::FLC_IDLE;
          next_c.status[`FLC_SR_BUSY]  = 1'b0;
          next_c.status[`FLC_SR_ARMED] = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      c        <= '0;
      c.state  <= flc_pkg::FLC_IDLE;
      c.status <= `FLC_SR_RESET;
      c.sel_prev <= 1'b1;
    end
    else
    begin
      c <= next_c;
    end
  end

  assign array_req_out = c.req;
  assign status_out    = c.status;
  assign wide_mode_out = c.wide;

  // ======================================================================
  // Link domain: frame start marker, cleared while select is high
  assign frame_rst_n = arst_n_in & ~select_n_in;

  always_ff @(posedge host_shift_clock_in or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      frame_open <= 1'b0;
    end
    else
    begin
      frame_open <= 1'b1;
    end
  end

  // ======================================================================
  // Link domain: capture on the rising edge
  logic [11:0] cnt;
  logic [11:0] cnt1;
  logic [2:0]  mod;
  logic [7:0]  sh_n;
  logic [7:0]  op_now;
  logic [11:0] abits;
  logic [11:0] rd_start;
  logic        busy_now;
  logic        is_rd;

  always_comb
  begin
    next_l   = l;
    cnt      = frame_open ? l.frame.bits : 12'h000;
    mod      = frame_open ? l.bit_mod : 3'h0;
    cnt1     = (cnt == `FLC_BITS_MAX) ? cnt : cnt + 12'h1;
    sh_n     = {l.shreg[6:0], serial_lane_zero_in};
    op_now   = (cnt == 12'd7) ? sh_n : l.frame.opcode;
    busy_now = (cnt == 12'd7) ? link_view[`FLC_SR_BUSY] : l.busy_at_op;
    abits    = link_view[8] ? `FLC_ADDR_WIDE : `FLC_ADDR_NARROW;
    rd_start = `FLC_OP_BITS + abits +
               ((op_now == `FLC_OP_FAST_READ) ? `FLC_DUMMY_BITS : 12'h0);
    is_rd    = ((op_now == `FLC_OP_READ) || (op_now == `FLC_OP_FAST_READ)) &&
               !busy_now;
    if (!select_n_in)
    begin
      next_l.shreg      = sh_n;
      next_l.frame.bits = cnt1;
      next_l.bit_mod    = mod + 3'h1;
      if (cnt == 12'h0)
      begin
        next_l.frame.addr = 32'h0;
      end
      if (cnt == 12'd7)
      begin
        next_l.frame.opcode = sh_n;
        next_l.busy_at_op   = link_view[`FLC_SR_BUSY];
      end
      if (cnt >= `FLC_OP_BITS && cnt < `FLC_OP_BITS + abits)
      begin
        next_l.frame.addr = {l.frame.addr[30:0], serial_lane_zero_in};
      end
      if (cnt == ((op_now == `FLC_OP_WR_STATUS) ? 12'd15 :
                  `FLC_OP_BITS + abits + 12'd7))
      begin
        next_l.frame.data = sh_n;
      end
      if (is_rd && cnt1 == rd_start)
      begin
        next_l.rd_addr = next_l.frame.addr & `FLC_ADDR_MASK;
      end
      else if (is_rd && cnt1 > rd_start && next_l.bit_mod == 3'h0)
      begin
        next_l.rd_addr = (l.rd_addr + 32'h1) & `FLC_ADDR_MASK;
      end
      next_l.tx_active = ((op_now == `FLC_OP_RD_STATUS) &&
                          cnt1 >= `FLC_OP_BITS) ||
                         (is_rd && cnt1 >= rd_start);
    end
  end

  always_ff @(posedge host_shift_clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      l <= '0;
    end
    else
    begin
      l <= next_l;
    end
  end

  assign array_rd_addr_out = l.rd_addr;

  // ======================================================================
  // Link domain: drive on the falling edge, MSB of each byte first
  logic [7:0] src;

  always_comb
  begin
    next_t       = t;
    src          = (l.frame.opcode == `FLC_OP_RD_STATUS) ?
                   link_view[7:0] : array_rd_data_in;
    next_t.drive = l.tx_active & frame_open;
    if (l.bit_mod == 3'h0)
    begin
      next_t.lane = src[7];
      next_t.hold = src;
    end
    else
    begin
      next_t.lane = t.hold[3'h7 - l.bit_mod];
    end
  end

  always_ff @(negedge host_shift_clock_in or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      t <= '0;
    end
    else
    begin
      t <= next_t;
    end
  end

  assign serial_lane_zero_out      = t.lane;
  assign serial_lane_zero_oe_n_out = ~(t.drive & ~select_n_in);

endmodule

//--- flc_front_monitor.sv
// Checker of the serial flash command front, bound to flc_front.
// Assumes it sees only the top module's ports.
`timescale 1ns/1ps
module flc_front_monitor #(
  parameter logic [23:0] PROG_TICKS  = 24'd10000,
  parameter logic [23:0] ERASE_TICKS = 24'd20000
)
(
  // Clocks and reset
  input  wire logic                    clock_in,
  input  wire logic                    arst_n_in,
  input  wire logic                    host_shift_clock_in,
  // Link
  input  wire logic                    select_n_in,
  input  wire logic                    serial_lane_zero_oe_n_out,
  input  wire logic [31:0]             array_rd_addr_out,
  // Core
  input  wire flc_pkg::flc_array_req_t array_req_out,
  input  wire logic [7:0]              status_out
);
  // ======================================================================
  // Busy length counter
  localparam int P_LO = int'(PROG_TICKS) - 1;
  localparam int P_HI = int'(PROG_TICKS) + 1;
  localparam int E_LO = int'(ERASE_TICKS) - 1;
  localparam int E_HI = int'(ERASE_TICKS) + 1;
  logic [23:0] busy_cnt;
  always_ff @(posedge clock_in or negedge arst_n_in)
    if (!arst_n_in)
      busy_cnt <= 24'h000000;
    else if (status_out[0])
      busy_cnt <= busy_cnt + 24'h000001;
    else
      busy_cnt <= 24'h000000;

  // ======================================================================
  // Assertions
  spare_bit_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    status_out[7] == 1'b0) else $error("status bit 7 set");
  start_busy_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    array_req_out.start |-> status_out[0]) else $error("start without busy");
  start_idle_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    array_req_out.start |-> !$past(status_out[0])) else $error("start in busy");
  start_armed_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    array_req_out.start |-> $past(status_out[1])) else $error("start unarmed");
  bulk_clear_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    array_req_out.start && (array_req_out.op inside {8'hc7, 8'hc4})
    |-> ($past(status_out) & 8'h5c) == 8'h00) else $error("bulk protected");
  busy_hold_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    array_req_out.start |=> status_out[0] [*8]) else $error("busy short");
  busy_len_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    $fell(status_out[0]) |-> busy_cnt inside {[P_LO:P_HI], [E_LO:E_HI],
    [1999:2001]}) else $error("busy length wrong");
  cycle_end_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    $fell(status_out[0]) |-> !status_out[1]) else $error("latch kept");
  idle_lane_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    select_n_in |-> serial_lane_zero_oe_n_out) else $error("lane driven");
  sub_align_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    array_req_out.start && array_req_out.op == 8'h20
    |-> array_req_out.addr[11:0] == 12'h000) else $error("subsector align");
  addr_range_a: assert property (@(posedge host_shift_clock_in)
    disable iff (!arst_n_in) array_rd_addr_out[31:27] == 5'h00)
    else $error("read address range");

  // Main scenarios
  cover property (@(posedge clock_in) array_req_out.start);
  cover property (@(posedge clock_in) !serial_lane_zero_oe_n_out);
  cover property (@(posedge clock_in) $rose(status_out[1]));
endmodule

bind flc_front flc_front_monitor #(.PROG_TICKS(PROG_TICKS),
  .ERASE_TICKS(ERASE_TICKS)) flc_front_monitor_i (.clock_in(clock_in),
  .arst_n_in(arst_n_in), .host_shift_clock_in(host_shift_clock_in),
  .select_n_in(select_n_in),
  .serial_lane_zero_oe_n_out(serial_lane_zero_oe_n_out),
  .array_rd_addr_out(array_rd_addr_out), .array_req_out(array_req_out),
  .status_out(status_out));

//--- flc_host.sv
// Host model: drives select, shift clock and lane zero of the device.
// Assumes the bench calls frame() with no other frame in flight.
`timescale 1ns/1ps
module flc_host
(
  // Link to the device
  output logic      host_shift_clock_out,
  output logic      select_n_out,
  output logic      lane_out,
  input  wire logic lane_in,
  input  wire logic lane_oe_n_in
);
  initial
  begin
    host_shift_clock_out = 1'b0;
    select_n_out = 1'b1;
    lane_out = 1'b0;
  end

  // ======================================================================
  // One frame: ntx bits out MSB first, then nrx clocks sampled on rise
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
                       output logic [15:0] rx);
    rx = 16'h0000;
    #7;
    select_n_out = 1'b0;
    for (int i = 0; i < ntx + nrx; i++)
    begin
      lane_out = (i < ntx) ? tx[ntx-1-i] : ~lane_out;
      #16;
      host_shift_clock_out = 1'b1;
      if (i >= ntx)
        rx = {rx[14:0], (lane_oe_n_in ? 1'bx : lane_in)};
      #16;
      host_shift_clock_out = 1'b0;
    end
    #16;
    select_n_out = 1'b1;
    lane_out = ~lane_out;
  endtask
endmodule

//--- flc_pkg.sv
// Types of the serial flash command front.
// Assumes flc_cfg.svh is compiled alongside.
package flc_pkg;

  // ======================================================================
  // Core state
  typedef enum logic [1:0]
  {
    FLC_IDLE = 2'b01,
    FLC_BUSY = 2'b10
  } flc_core_state_t;

  // ======================================================================
  // Frame captured in the link domain
  typedef struct packed
  {
    logic [7:0]  opcode;
    logic [31:0] addr;
    logic [7:0]  data;
    logic [11:0] bits;
  } flc_frame_t;

  // Request to the memory array
  typedef struct packed
  {
    logic        start;
    logic [7:0]  op;
    logic [31:0] addr;
    logic [7:0]  data;
  } flc_array_req_t;

  // Core domain state
  typedef struct packed
  {
    flc_core_state_t state;
    logic [7:0]      status;
    logic            wide;
    logic            strap_done;
    logic            sel_prev;
    logic [23:0]     timer;
    flc_array_req_t  req;
  } flc_core_t;

  // Link domain state, rising edge
  typedef struct packed
  {
    flc_frame_t  frame;
    logic [7:0]  shreg;
    logic [2:0]  bit_mod;
    logic        busy_at_op;
    logic        tx_active;
    logic [31:0] rd_addr;
  } flc_link_t;

  // Link domain state, falling edge
  typedef struct packed
  {
    logic       drive;
    logic       lane;
    logic [7:0] hold;
  } flc_tx_t;

endpackage

//--- flc_protect.sv
// Decoder of the protected sector region from the block-protect code.
// Assumes the largest array of 2048 sectors of 64 KB.
`timescale 1ns/1ps
`include "flc_cfg.svh"
module flc_protect
(
  // Protection setting
  input  wire logic [3:0]  bp_in,
  input  wire logic        bottom_in,
  // Target
  input  wire logic [10:0] sector_in,
  output logic             hit_out
);
  logic [11:0] size;
  logic [11:0] from_top;

  // ======================================================================
  // Region size is 2^(code-1) sectors, code 12 and above covers all
  always_comb
  begin
    size     = (bp_in == 4'h0) ? 12'h000 : (12'h001 << (bp_in - 4'h1));
    from_top = 12'h7ff - {1'b0, sector_in};
    if (bp_in == 4'h0)
    begin
      hit_out = 1'b0;
    end
    else if (bp_in >= `FLC_BP_ALL)
    begin
      hit_out = 1'b1;
    end
    else if (bottom_in)
    begin
      hit_out = {1'b0, sector_in} < size;
    end
    else
    begin
      hit_out = from_top < size;
    end
  end
endmodule

//--- flc_sync.sv
// Three-stage synchroniser for a bundle of levels.
// Assumes each bit is a quasi-static level; a change counts once the
// second and third stages agree.
`timescale 1ns/1ps
module flc_sync #(parameter int W = 1)
(
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ======================================================================
  // Stages and agreement filter
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      q_out <= '0;
    end
    else
    begin
      s1    <= d_in;
      s2    <= s1;
      s3    <= s2;
      for (int i = 0; i < W; i++)
      begin
        if (s2[i] == s3[i])
        begin
          q_out[i] <= s3[i];
        end
      end
    end
  end
endmodule

//--- tb.sv
// Testbench of the serial flash command front.
// Assumes flc_front_monitor is bound and flc_host plays the host.
`timescale 1ns/1ps
module tb;
  // ======================================================================
  // Signals
  logic                    clock_in;
  logic                    arst_n_in;
  logic                    wide_mode_saved_in;
  logic                    sclk;
  logic                    sel_n;
  logic                    lane_in;
  logic                    lane_out;
  logic                    lane_oe_n;
  logic                    wide;
  logic [31:0]             rd_addr;
  logic [7:0]              status;
  logic [15:0]             rx;
  flc_pkg::flc_array_req_t req;
  flc_pkg::flc_array_req_t last_req;
  int                      bad_count;
  int                      num_checks;
  int                      n_start;

  flc_front #(.PROG_TICKS(24'd400), .ERASE_TICKS(24'd800)) flc_front_i (
    .clock_in(clock_in), .arst_n_in(arst_n_in),
    .host_shift_clock_in(sclk), .select_n_in(sel_n),
    .serial_lane_zero_in(lane_in), .serial_lane_zero_out(lane_out),
    .serial_lane_zero_oe_n_out(lane_oe_n), .array_rd_addr_out(rd_addr),
    .array_rd_data_in(rd_addr[7:0] ^ 8'ha5), .array_req_out(req),
    .status_out(status), .wide_mode_out(wide),
    .wide_mode_saved_in(wide_mode_saved_in));
  flc_host flc_host_i (.host_shift_clock_out(sclk), .select_n_out(sel_n),
    .lane_out(lane_in), .lane_in(lane_out), .lane_oe_n_in(lane_oe_n));

  initial
  begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  always @(posedge clock_in)
    if (req.start === 1'b1)
    begin
      n_start = n_start + 1;
      last_req = req;
    end

  // ======================================================================
  // Shared tasks
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [63:0] tx, input int n);
    flc_host_i.frame(tx, n, 0, rx);
    repeat (8) @(posedge clock_in);
  endtask

  task automatic read(input logic [63:0] tx, input int n,
                      input logic [15:0] exp);
    flc_host_i.frame(tx, n, 16, rx);
    check(48'(rx), 48'(exp));
    repeat (8) @(posedge clock_in);
  endtask

  task automatic wait_idle;
    int i;
    i = 0;
    while (status[0] !== 1'b0 && i < 5000)
    begin
      @(posedge clock_in);
      i++;
    end
    if (i >= 5000)
    begin
      bad_count++;
      print_verdict();
    end
  endtask

  task automatic do_reset(input logic saved);
    @(posedge clock_in);
    arst_n_in <= 1'b0;
    wide_mode_saved_in <= saved;
    repeat (2) @(posedge clock_in);
    check({status, wide, lane_oe_n}, {8'h00, 1'b0, 1'b1});
    arst_n_in <= 1'b1;
    repeat (6) @(posedge clock_in);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ======================================================================
  // Scenarios
  task automatic t_wide;
    send(8'hb7, 8);
    check(wide, 1'b1);
    send(8'he9, 8);
    check(wide, 1'b0);
    read({8'h03, 24'h000102}, 32, 16'ha7a6);
    do_reset(1'b1);
    check(wide, 1'b1);
  endtask

  task automatic t_arm;
    read(8'h05, 8, 16'h0000);
    send(8'h06, 8);
    read(8'h05, 8, 16'h0202);
    send(8'h04, 8);
    check(status, 8'h00);
  endtask

  task automatic t_write;
    int n0;
    send(8'h06, 8);
    n0 = n_start;
    send({8'h02, 32'h07fff123, 8'h3c}, 48);
    check(48'(n_start), 48'(n0 + 1));
    check({last_req.op, last_req.addr, last_req.data},
          {8'h02, 32'h07fff123, 8'h3c});
    read(8'h05, 8, 16'h0303);
    read({8'h03, 32'h00000010}, 40, 16'hxxxx);
    send({8'h02, 32'h00000020, 8'h77}, 48);
    check(48'(n_start), 48'(n0 + 1));
    wait_idle();
    check(status, 8'h00);
  endtask

  task automatic t_refuse;
    int n0;
    send(8'h06, 8);
    n0 = n_start;
    send({8'h02, 32'h00000100, 8'h11, 7'h1f}, 55);
    check(48'(n_start), 48'(n0));
    check(status, 8'h02);
    send(8'h04, 8);
    send({8'h02, 32'h00000100, 8'h11}, 48);
    check(48'(n_start), 48'(n0));
  endtask

  task automatic t_protect;
    int n0;
    send(8'h06, 8);
    send({8'h01, 8'h24}, 16);
    wait_idle();
    check(status, 8'h24);
    n0 = n_start;
    send(8'h06, 8);
    send({8'hd8, 32'h00008000}, 40);
    send(8'hc7, 8);
    check(48'(n_start), 48'(n0));
    send(8'h06, 8);
    send({8'h20, 32'h00012345}, 40);
    check(48'(last_req.addr), 48'h000000012000);
    wait_idle();
    send(8'h06, 8);
    send({8'h01, 8'h00}, 16);
    wait_idle();
    send(8'h06, 8);
    send(8'hc7, 8);
    check(48'(n_start), 48'(n0 + 3));
    wait_idle();
    send(8'h06, 8);
    send(8'hc4, 8);
    check({8'h00, last_req.op, last_req.addr}, {16'h00c4, 32'h0});
    wait_idle();
  endtask

  // ======================================================================
  // Main sequence and watchdog
  initial
  begin
    arst_n_in = 1'b0;
    wide_mode_saved_in = 1'b0;
    bad_count = 0;
    num_checks = 0;
    n_start = 0;
    do_reset(1'b0);
    t_wide();
    t_arm();
    t_write();
    t_refuse();
    t_protect();
    read({8'h03, 32'h07fffffe}, 40, 16'h5b5a);
    read({8'h0b, 32'h00000040, 8'h00}, 48, 16'he5e4);
    print_verdict();
  end

  initial
  begin
    #2000000;
    bad_count++;
    print_verdict();
  end
endmodule
